// file: core/usart_rx.sv
// Serial receiver with nine-bit frames, address detect and AXI4-Lite registers
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Contract
// R1: Software clears sync mode and sets port enable after programming the divisor.
// R2: Frames are received only while continuous receive enable bit 4 is set; the code also receives while single receive enable bit 5 is set.
// R3: Completed reception sets the flag; interrupt only when its enable is set.
// R4: Software reads status for ninth bit and errors before the data register.
// R5: Clearing continuous receive enable resets the receiver error state.
// R6: Nine-bit enable receives 9 bits; ninth goes to the status ninth field.
// R7: Address detect bit 3 together with nine-bit enable turns detection on.
// R8: With detection, ninth bit copied and flag set only if it is 1.
// R9: Transmitter marks address frames with ninth bit 1, data with 0.
// R10: Master sends an address frame before data frames to a slave.
// R11: With detection, ninth-bit-0 frames are not buffered and raise nothing.
// R12: Ignored frame in the shift register is overwritten by the next one.
// R13: Address detect has no effect outside nine-bit frames.
// R14: Without detection every frame is buffered, ninth bit left to software.
// R15: Addressed slave software clears address detect and the receive flag.
// R16: Address-detect reception works with continuous or single receive enable.
// R17: Flag clears only when data has been read and buffer is empty.
// R18: Third frame with full buffer sets overrun bit 1 and is lost.
// R19: While overrun is set, no transfer into the receive buffer happens.
// R20: Stop bit low sets framing error bit 2, buffered with each byte.
// R21: Frame: low start, data LSB first, optional ninth, high stop.
module usart_rx (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rx_pin,
  output logic             irq_request
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    usart_rx_pkg::ctl_s      ctl;
    logic                    aw_got;
    logic [9:0]              aw_idx;
    logic                    w_got;
    logic [7:0]              w_byte;
    logic                    w_lane;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
    logic                    sync1;
    logic                    sync2;
    logic                    sync3;
    logic                    rx_level;
    logic [7:0]              pre;
    logic [1:0]              sub;
    usart_rx_pkg::rx_state_e rx_state;
    logic [3:0]              os_cnt;
    logic [3:0]              bit_cnt;
    logic [8:0]              shift;
    usart_rx_pkg::rx_entry_s fifo0;
    usart_rx_pkg::rx_entry_s fifo1;
    logic                    head;
    logic [1:0]              count;
    logic                    overrun_error_flag;
  } state_s;

  state_s st;
  state_s next_st;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic                    rx_en;
  logic                    os_tick;
  logic                    frame_end;
  logic                    addr_mode;
  logic                    accept;
  logic                    push;
  logic                    pop;
  logic                    wr_fire;
  logic [9:0]              ar_idx;
  usart_rx_pkg::rx_entry_s head_entry;
  usart_rx_pkg::rx_entry_s new_entry;

  // ****************************************************************
  // Derived terms
  // ****************************************************************
  // Sync mode is outside this block, so it simply keeps the receiver idle
  assign rx_en      = st.ctl.port_en && !st.ctl.sync_mode &&
                      (st.ctl.cont_rx || st.ctl.single_rx);                  // see R2, R16
  assign os_tick    = (st.pre == 8'h00) &&
                      (st.ctl.high_speed || st.sub == usart_rx_pkg::LOW_SPEED_LAST);
  assign frame_end  = (st.rx_state == usart_rx_pkg::RX_STOP) && os_tick &&
                      (st.os_cnt == usart_rx_pkg::OS_BIT_LAST);
  assign addr_mode  = st.ctl.addr_det && st.ctl.nine_bit;                   // see R7, R13
  assign accept     = !addr_mode || st.shift[8];                            // see R8, R11, R14
  assign push       = frame_end && accept && !st.overrun_error_flag &&
                      (st.count != usart_rx_pkg::FIFO_DEPTH);               // see R18, R19
  assign ar_idx     = araddr[11:2];
  assign pop        = arvalid && !st.rvalid && (ar_idx == usart_rx_pkg::IDX_RX_DATA) &&
                      (st.count != 2'h0);
  assign wr_fire    = st.aw_got && st.w_got && !st.bvalid;
  assign head_entry = st.head ? st.fifo1 : st.fifo0;
  assign new_entry  = '{framing_error_flag: !st.rx_level,
                        ninth: st.ctl.nine_bit & st.shift[8],
                        data: st.shift[7:0]};                               // see R6, R20

  assign awready     = !st.aw_got && !st.bvalid;
  assign wready      = !st.w_got && !st.bvalid;
  assign arready     = !st.rvalid;
  assign bvalid      = st.bvalid;
  assign bresp       = st.bresp;
  assign rvalid      = st.rvalid;
  assign rresp       = st.rresp;
  assign rdata       = {24'h000000, st.rdata};
  assign irq_request = (st.count != 2'h0) && st.ctl.rx_irq_en;              // see R3

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    // Three-stage pin capture; a level counts once stages two and three agree
    {next_st.sync3, next_st.sync2, next_st.sync1} = {st.sync2, st.sync1, rx_pin};
    if (st.sync2 == st.sync3) begin
      next_st.rx_level = st.sync3;
    end
    // Baud generator held in reset while receive is off
    if (!rx_en) begin
      next_st.pre = st.ctl.baud_divisor;
      next_st.sub = 2'h0;
    end else if (st.pre == 8'h00) begin
      next_st.pre = st.ctl.baud_divisor;
      next_st.sub = st.sub + 2'h1;
    end else begin
      next_st.pre = st.pre - 8'h01;
    end
    // Frame recovery, sixteen samples per bit
    if (!rx_en) begin
      next_st.rx_state = usart_rx_pkg::RX_IDLE;                             // see R2, R5
    end else begin
      case (st.rx_state)
        usart_rx_pkg::RX_IDLE: begin
          if (!st.rx_level) begin
            next_st.rx_state = usart_rx_pkg::RX_START;                      // see R21
            next_st.os_cnt   = 4'h0;
            next_st.bit_cnt  = 4'h0;
          end
        end
        usart_rx_pkg::RX_START: begin
          if (os_tick) begin
            next_st.os_cnt = st.os_cnt + 4'h1;
            if (st.os_cnt == usart_rx_pkg::OS_START_MID) begin
              next_st.os_cnt   = 4'h0;
              // Old ignored frame is dropped here, not kept around
              next_st.shift    = 9'h000;                                    // see R12
              next_st.rx_state = st.rx_level ? usart_rx_pkg::RX_IDLE : usart_rx_pkg::RX_DATA;
            end
          end
        end
        usart_rx_pkg::RX_DATA: begin
          if (os_tick) begin
            next_st.os_cnt = st.os_cnt + 4'h1;
            if (st.os_cnt == usart_rx_pkg::OS_BIT_LAST) begin
              next_st.shift[st.bit_cnt] = st.rx_level;                      // see R21
              next_st.bit_cnt           = st.bit_cnt + 4'h1;
              if (st.bit_cnt == (st.ctl.nine_bit ? usart_rx_pkg::BITS_NINE
                                                 : usart_rx_pkg::BITS_EIGHT)) begin
                next_st.rx_state = usart_rx_pkg::RX_STOP;                   // see R6
              end
            end
          end
        end
        usart_rx_pkg::RX_STOP: begin
          if (os_tick) begin
            next_st.os_cnt = st.os_cnt + 4'h1;
            if (st.os_cnt == usart_rx_pkg::OS_BIT_LAST) begin
              next_st.rx_state = usart_rx_pkg::RX_IDLE;
              if (!st.ctl.cont_rx) begin
                next_st.ctl.single_rx = 1'b0;
              end
            end
          end
        end
        default: begin
          next_st.rx_state = usart_rx_pkg::RX_IDLE;
        end
      endcase
    end
    // Two-deep receive buffer; the receive flag clears only once software reads have emptied it
    if (push) begin
      if (st.head ^ st.count[0]) begin
        next_st.fifo1 = new_entry;
      end else begin
        next_st.fifo0 = new_entry;
      end
    end
    next_st.head  = st.head ^ pop;                                          // see R17
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    if (frame_end && accept && !st.overrun_error_flag && st.count == usart_rx_pkg::FIFO_DEPTH) begin
      next_st.overrun_error_flag = 1'b1;                                                  // see R18
    end
    if (!st.ctl.cont_rx) begin
      next_st.overrun_error_flag = 1'b0;                                                  // see R5
    end
    // Write channel: address and data may arrive in either order
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_idx = awaddr[11:2];
    end
    if (wvalid && wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_byte = wdata[7:0];
      next_st.w_lane = wstrb[0];
    end
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = usart_rx_pkg::RESP_OKAY;
      case (st.aw_idx)
        usart_rx_pkg::IDX_RX_STATUS: begin
          if (st.w_lane) begin
            next_st.ctl.port_en   = st.w_byte[usart_rx_pkg::BIT_PORT_EN];   // see R1
            next_st.ctl.nine_bit  = st.w_byte[usart_rx_pkg::BIT_NINE_BIT];
            next_st.ctl.single_rx = st.w_byte[usart_rx_pkg::BIT_SINGLE_RX];
            next_st.ctl.cont_rx   = st.w_byte[usart_rx_pkg::BIT_CONT_RX];
            next_st.ctl.addr_det  = st.w_byte[usart_rx_pkg::BIT_ADDR_DET];  // see R15
          end
        end
        usart_rx_pkg::IDX_IRQ_ENABLES: begin
          if (st.w_lane) begin
            next_st.ctl.rx_irq_en = st.w_byte[usart_rx_pkg::BIT_RX_IRQ];
          end
        end
        usart_rx_pkg::IDX_TX_STATUS: begin
          if (st.w_lane) begin
            next_st.ctl.sync_mode  = st.w_byte[usart_rx_pkg::BIT_SYNC_MODE];
            next_st.ctl.high_speed = st.w_byte[usart_rx_pkg::BIT_HIGH_SPEED];
          end
        end
        usart_rx_pkg::IDX_BAUD_DIVISOR: begin
          if (st.w_lane) begin
            next_st.ctl.baud_divisor = st.w_byte;
          end
        end
        // Flags and data are read-only; writes there are ignored quietly
        usart_rx_pkg::IDX_IRQ_FLAGS, usart_rx_pkg::IDX_RX_DATA: begin
          next_st.bresp = usart_rx_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = usart_rx_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read channel; reading data pops the buffer and exposes the next status
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = usart_rx_pkg::RESP_OKAY;
      next_st.rdata  = 8'h00;
      case (ar_idx)
        usart_rx_pkg::IDX_IRQ_FLAGS: begin
          next_st.rdata[usart_rx_pkg::BIT_RX_IRQ] = (st.count != 2'h0);     // see R3
        end
        usart_rx_pkg::IDX_RX_STATUS: begin
          next_st.rdata = {st.ctl.port_en, st.ctl.nine_bit, st.ctl.single_rx,
                           st.ctl.cont_rx, st.ctl.addr_det,
                           (st.count != 2'h0) && head_entry.framing_error_flag, st.overrun_error_flag,
                           (st.count != 2'h0) && head_entry.ninth};         // see R4, R20
        end
        usart_rx_pkg::IDX_RX_DATA: begin
          next_st.rdata = (st.count != 2'h0) ? head_entry.data : 8'h00;
        end
        usart_rx_pkg::IDX_IRQ_ENABLES: begin
          next_st.rdata[usart_rx_pkg::BIT_RX_IRQ] = st.ctl.rx_irq_en;
        end
        usart_rx_pkg::IDX_TX_STATUS: begin
          next_st.rdata[usart_rx_pkg::BIT_SYNC_MODE]   = st.ctl.sync_mode;
          next_st.rdata[usart_rx_pkg::BIT_HIGH_SPEED]  = st.ctl.high_speed;
          next_st.rdata[usart_rx_pkg::BIT_SHIFT_EMPTY] = 1'b1;
        end
        usart_rx_pkg::IDX_BAUD_DIVISOR: begin
          next_st.rdata = st.ctl.baud_divisor;
        end
        default: begin
          next_st.rresp = usart_rx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                  <= '0;
      st.ctl.high_speed   <= usart_rx_pkg::RST_TX_STATUS[usart_rx_pkg::BIT_HIGH_SPEED];
      st.ctl.baud_divisor <= usart_rx_pkg::RST_BYTE;
      {st.sync1, st.sync2, st.sync3, st.rx_level} <= 4'hF;
      st.rx_state         <= usart_rx_pkg::RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_irq_gated;
    push && st.ctl.rx_irq_en |=> irq_request;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq missing after push"); // see R3
  property p_idle_when_off;
    !rx_en |=> st.rx_state == usart_rx_pkg::RX_IDLE;
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("receiver active while off"); // see R2
  property p_overrun_error_flag_clear;
    !st.ctl.cont_rx |=> !st.overrun_error_flag;
  endproperty
  a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear) else $error("overrun kept after enable clear"); // see R5
  property p_addr_ignore;
    frame_end && addr_mode && !st.shift[8] && !pop |=> st.count == $past(st.count);
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("data frame buffered in address mode"); // see R11
  property p_overrun_set;
    frame_end && accept && st.count == 2'h2 && st.ctl.cont_rx && !pop |=> st.overrun_error_flag && st.count == 2'h2;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged"); // see R18
  property p_overrun_block;
    st.overrun_error_flag |=> st.count <= $past(st.count);
  endproperty
  a_overrun_block: assert property (p_overrun_block) else $error("buffer grew during overrun"); // see R19
  property p_flag_clear;
    pop && st.count == 2'h1 && !push |=> st.count == 2'h0 && !irq_request;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag stuck after last read"); // see R17
  property p_eight_bit_accept;
    frame_end && !st.ctl.nine_bit && !st.overrun_error_flag && st.count == 2'h0 |=> st.count == 2'h1;
  endproperty
  a_eight_bit_accept: assert property (p_eight_bit_accept) else $error("frame lost in eight-bit mode"); // see R13
  property p_bvalid_hold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped"); // see R1
  c_push:      cover property (@(posedge aclk) disable iff (!aresetn) push);
  c_overrun:   cover property (@(posedge aclk) disable iff (!aresetn) $rose(st.overrun_error_flag));
  c_ignored:   cover property (@(posedge aclk) disable iff (!aresetn) frame_end && !accept);
  c_data_read: cover property (@(posedge aclk) disable iff (!aresetn) pop);

endmodule

// file: core/usart_rx_pkg.sv
// Shared constants and types for the serial receiver with address detect
package usart_rx_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] IDX_IRQ_FLAGS    = 10'h00C;
  localparam logic [9:0] IDX_RX_STATUS    = 10'h018;
  localparam logic [9:0] IDX_RX_DATA      = 10'h01A;
  localparam logic [9:0] IDX_IRQ_ENABLES  = 10'h08C;
  localparam logic [9:0] IDX_TX_STATUS    = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIVISOR = 10'h099;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_RX_IRQ      = 5;
  localparam int BIT_PORT_EN     = 7;
  localparam int BIT_NINE_BIT    = 6;
  localparam int BIT_SINGLE_RX   = 5;
  localparam int BIT_CONT_RX     = 4;
  localparam int BIT_ADDR_DET    = 3;
  localparam int BIT_FRAME_ERR   = 2;
  localparam int BIT_OVERRUN     = 1;
  localparam int BIT_NINTH       = 0;
  localparam int BIT_SYNC_MODE   = 4;
  localparam int BIT_HIGH_SPEED  = 2;
  localparam int BIT_SHIFT_EMPTY = 1;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] RST_TX_STATUS   = 8'h02;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [3:0] OS_START_MID    = 4'h7;
  localparam logic [3:0] OS_BIT_LAST     = 4'hF;
  localparam logic [1:0] LOW_SPEED_LAST  = 2'h3;
  localparam logic [1:0] FIFO_DEPTH      = 2'h2;
  localparam logic [3:0] BITS_EIGHT      = 4'h7;
  localparam logic [3:0] BITS_NINE       = 4'h8;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  typedef struct packed {
    logic       framing_error_flag;
    logic       ninth;
    logic [7:0] data;
  } rx_entry_s;

  typedef struct packed {
    logic        port_en;
    logic        nine_bit;
    logic        single_rx;
    logic        cont_rx;
    logic        addr_det;
    logic        sync_mode;
    logic        high_speed;
    logic        rx_irq_en;
    logic [7:0]  baud_divisor;
  } ctl_s;

endpackage

// file: tb/serial_tx_model.sv
// Behavioural serial transmitter driving the receive line
`timescale 1ns/1ns
module serial_tx_model (
  input  wire logic       aclk,
  input  wire logic [7:0] bit_clks,
  input  wire logic       go,
  input  wire logic [8:0] frame,
  input  wire logic       nine,
  input  wire logic       stop_bit,
  output logic            line,
  output logic            busy
);
  int i;

  // ****************************************************************
  // Frame generator
  // ****************************************************************
  // Line idles high, as with the pull-up on a released line
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        line <= 1'b0;
        repeat (bit_clks) @(posedge aclk);
        for (i = 0; i < (nine ? 9 : 8); i++) begin
          line <= frame[i];
          repeat (bit_clks) @(posedge aclk);
        end
        // Low stop only when a scenario asks for a broken frame
        line <= stop_bit;
        repeat (bit_clks) @(posedge aclk);
        line <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: tb/test_usart_rx.sv
// Self-checking bench for the serial receiver with address detect
`timescale 1ns/1ns
module test_usart_rx;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, nine, stop_bit;
  logic        awready, wready, bvalid, arready, rvalid, irq_request, rx_pin, busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [8:0]  frame;
  logic [7:0]  bit_clks;
  int          n_fail, num_checks;

  usart_rx DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_pin, .irq_request);
  serial_tx_model far_tx (.aclk, .bit_clks, .go, .frame, .nine, .stop_bit, .line(rx_pin), .busy);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang;
    n_fail++;
    $display("mismatch handshake expected done seen timeout");
    test_done();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus tasks wait one extra edge so ready/valid never toggle twice in a step
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er = usart_rx_pkg::RESP_OKAY);
    int k;
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 50) hang();
    chk("bresp", er, bresp);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er = usart_rx_pkg::RESP_OKAY);
    int k;
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 50) hang();
    chk("rresp", er, rresp);
    chk($sformatf("reg %h", i), {24'h0, e}, rdata);
    @(posedge aclk);
  endtask

  // Waits past the stop bit so the receiver has finished its frame end
  task automatic send(input logic [8:0] f, input logic n9, input logic sb);
    int k;
    frame <= f;
    nine <= n9;
    stop_bit <= sb;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (k = 0; k < 1500 && (k < 2 || busy); k++) @(posedge aclk);
    if (busy) hang();
    repeat (8) @(posedge aclk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, nine} = '0;
    {awaddr, araddr, wdata, frame} = '0;
    stop_bit = 1'b1;
    bit_clks = 8'h10;
    wstrb = 4'hF;
    n_fail = 0;
    num_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h00);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h00);
    rd(usart_rx_pkg::IDX_IRQ_ENABLES, 8'h00);
    rd(usart_rx_pkg::IDX_TX_STATUS, 8'h02);
    rd(usart_rx_pkg::IDX_BAUD_DIVISOR, 8'h00);
    rd(10'h001, 8'h00, usart_rx_pkg::RESP_SLVERR);
    wr(10'h001, 8'hFF, usart_rx_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(usart_rx_pkg::IDX_BAUD_DIVISOR, 8'h00);
    wr(usart_rx_pkg::IDX_TX_STATUS, 8'h04);
    wr(usart_rx_pkg::IDX_IRQ_ENABLES, 8'h20);
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'h80);
    send(9'h055, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'h90);
    send(9'h0A5, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h20);
    chk("irq_request", 1, irq_request);
    wr(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h20);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h90);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'hA5);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    chk("irq_request", 0, irq_request);
    $display("test basic done");
    wr(usart_rx_pkg::IDX_TX_STATUS, 8'h14);
    rd(usart_rx_pkg::IDX_TX_STATUS, 8'h16);
    send(9'h066, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    wr(usart_rx_pkg::IDX_TX_STATUS, 8'h04);
    $display("test sync mode done");
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'hD8);
    send(9'h011, 1'b1, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    send(9'h13C, 1'b1, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h20);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'hD9);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h3C);
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'hD0);
    wr(usart_rx_pkg::IDX_IRQ_ENABLES, 8'h00);
    send(9'h0C3, 1'b1, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h20);
    chk("irq_request", 0, irq_request);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'hD0);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'hC3);
    wr(usart_rx_pkg::IDX_IRQ_ENABLES, 8'h20);
    $display("test address detect done");
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'h98);
    send(9'h07E, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h7E);
    send(9'h0F0, 1'b0, 1'b0);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h9C);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'hF0);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h98);
    $display("test framing done");
    wr(usart_rx_pkg::IDX_TX_STATUS, 8'h00);
    bit_clks <= 8'h40;
    send(9'h05A, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h5A);
    wr(usart_rx_pkg::IDX_TX_STATUS, 8'h04);
    wr(usart_rx_pkg::IDX_BAUD_DIVISOR, 8'h03);
    send(9'h0A6, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'hA6);
    wr(usart_rx_pkg::IDX_BAUD_DIVISOR, 8'h00);
    bit_clks <= 8'h10;
    $display("test baud rates done");
    send(9'h001, 1'b0, 1'b1);
    send(9'h002, 1'b0, 1'b1);
    send(9'h003, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h9A);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h01);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h02);
    send(9'h004, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_IRQ_FLAGS, 8'h00);
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'h88);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h88);
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'h98);
    send(9'h005, 1'b0, 1'b1);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'h05);
    $display("test overrun done");
    wr(usart_rx_pkg::IDX_RX_STATUS, 8'hE8);
    send(9'h1AA, 1'b1, 1'b1);
    rd(usart_rx_pkg::IDX_RX_DATA, 8'hAA);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'hC8);
    $display("test single receive done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(usart_rx_pkg::IDX_RX_STATUS, 8'h00);
    rd(usart_rx_pkg::IDX_TX_STATUS, 8'h02);
    $display("test second reset done");
    test_done();
  end
endmodule
